// ---- mrs_pkg.sv ----
// mrs_pkg: constants for the measurement result shadow block.
// assumes: shared by the core-domain logic, the link logic and the fifo.
package mrs_pkg;

  // result field widths and the packed result word
  localparam int MRS_PT_W   = 20;
  localparam int MRS_HUM_W  = 16;
  localparam int MRS_WORD_W = 2 * MRS_PT_W + MRS_HUM_W;
  localparam int MRS_BYTE_W = 8;

  // field positions inside the packed result word
  localparam int MRS_HUM_LSB   = 0;
  localparam int MRS_TEMP_LSB  = 16;
  localparam int MRS_PRESS_LSB = 36;

  // fifo depth in the measurement path
  localparam int MRS_FIFO_DEPTH = 8;

  // byte addresses of the result window
  localparam logic [7:0] MRS_A_PRESS_MSB  = 8'hF7;
  localparam logic [7:0] MRS_A_PRESS_LSB  = 8'hF8;
  localparam logic [7:0] MRS_A_PRESS_XLSB = 8'hF9;
  localparam logic [7:0] MRS_A_TEMP_MSB   = 8'hFA;
  localparam logic [7:0] MRS_A_TEMP_LSB   = 8'hFB;
  localparam logic [7:0] MRS_A_TEMP_XLSB  = 8'hFC;
  localparam logic [7:0] MRS_A_HUM_MSB    = 8'hFD;
  localparam logic [7:0] MRS_A_HUM_LSB    = 8'hFE;

  // value loaded into a skipped temperature or pressure result
  localparam logic [19:0] MRS_SKIP_MARKER = 20'h8_0000;

  // reset values
  localparam logic [MRS_WORD_W-1:0] MRS_RESULT_RST = '0;
  localparam logic [7:0]            MRS_ADDR_RST   = 8'h00;
  localparam logic [7:0]            MRS_BYTE_RST   = 8'h00;

endpackage : mrs_pkg

// ---- mrs_sync.sv ----
// mrs_sync: two flip-flop level synchroniser.
// assumes: din comes from another clock domain or a pin.
`timescale 1ns/1ps
module mrs_sync
  import mrs_pkg::*;
#(
  parameter logic RST_VAL = 1'b0
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // level in and synchronised level out
  input  wire logic din,
  output logic      dout
);

  logic meta_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= RST_VAL;
      dout   <= RST_VAL;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end

endmodule : mrs_sync

// ---- mrs_fifo.sv ----
// mrs_fifo: synchronous fifo with valid/ready on both sides.
// assumes: one clock; depth is a power of two.
`timescale 1ns/1ps
module mrs_fifo
  import mrs_pkg::*;
#(
  parameter int WIDTH = MRS_WORD_W,
  parameter int DEPTH = MRS_FIFO_DEPTH
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      rd_q;
  logic             push;
  logic             pop;

  assign in_ready  = (wr_q - rd_q) != (AW+1)'(DEPTH);
  assign out_valid = wr_q != rd_q;
  assign out_data  = mem_q[rd_q[AW-1:0]];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end

endmodule : mrs_fifo

// ---- mrs_top.sv ----
// mrs_top: result register window with shadowing of late measurements.
// assumes: measurements arrive on core_clk; the serial front end runs on
// link_clk and hands over start/stop, address and byte requests.
`timescale 1ns/1ps
module mrs_top
  import mrs_pkg::*;
(
  // core clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 sys_rst,
  // measurement results from the sequencer
  input  wire logic                 meas_valid,
  output logic                      meas_ready,
  input  wire logic [MRS_PT_W-1:0]  raw_temperature,
  input  wire logic [MRS_PT_W-1:0]  raw_pressure,
  input  wire logic [MRS_HUM_W-1:0] raw_humidity,
  input  wire logic                 temp_skipped,
  input  wire logic                 press_skipped,
  // link side, clocked by the serial front end
  input  wire logic                 link_clk,
  input  wire logic                 chip_select_n,
  input  wire logic                 i2c_start,
  input  wire logic                 i2c_stop,
  input  wire logic                 addr_load,
  input  wire logic [7:0]           addr_in,
  input  wire logic                 byte_req,
  output logic [MRS_BYTE_W-1:0]     rdata,
  output logic                      rdata_valid
);

  // core domain
  logic [MRS_WORD_W-1:0] in_word;
  logic [MRS_PT_W-1:0]   temp_in;
  logic [MRS_PT_W-1:0]   press_in;
  logic                  f_valid;
  logic                  f_ready;
  logic [MRS_WORD_W-1:0] f_data;
  logic                  pop;
  logic [MRS_WORD_W-1:0] user_q;
  logic [MRS_WORD_W-1:0] shadow_q;
  logic                  pend_q;
  logic                  cs_n_s;
  logic                  i2c_busy_s;
  logic                  busy_s;
  logic                  busy_q;
  logic                  burst_end;
  logic                  i2c_busy_q;

  assign temp_in  = temp_skipped  ? MRS_SKIP_MARKER : raw_temperature;
  assign press_in = press_skipped ? MRS_SKIP_MARKER : raw_pressure;
  assign in_word  = {press_in, temp_in, raw_humidity};

  mrs_fifo #(
    .WIDTH (MRS_WORD_W),
    .DEPTH (MRS_FIFO_DEPTH)
  ) u_fifo (
    .clk       (core_clk),
    .rst       (sys_rst),
    .in_valid  (meas_valid),
    .in_ready  (meas_ready),
    .in_data   (in_word),
    .out_valid (f_valid),
    .out_ready (f_ready),
    .out_data  (f_data)
  );

  mrs_sync #(.RST_VAL(1'b1)) u_sync_cs (
    .clk  (core_clk),
    .rst  (sys_rst),
    .din  (chip_select_n),
    .dout (cs_n_s)
  );

  mrs_sync #(.RST_VAL(1'b0)) u_sync_i2c (
    .clk  (core_clk),
    .rst  (sys_rst),
    .din  (i2c_busy_q),
    .dout (i2c_busy_s)
  );

  assign busy_s = ~cs_n_s | i2c_busy_s;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= busy_s;
    end
  end

  assign burst_end = busy_q & ~busy_s;
  // commit cycle stalls the drain so shadow and user never race
  assign f_ready   = ~burst_end;
  assign pop       = f_valid & f_ready;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      shadow_q <= MRS_RESULT_RST;
    end else if (pop && busy_s) begin
      shadow_q <= f_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pend_q <= 1'b0;
    end else if (pop && busy_s) begin
      pend_q <= 1'b1;
    end else if (burst_end) begin
      pend_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      user_q <= MRS_RESULT_RST;
    end else if (burst_end && pend_q) begin
      user_q <= shadow_q;
    end else if (pop && !busy_s) begin
      user_q <= f_data;
    end
  end

  // link domain
  logic                  link_rst;
  logic [7:0]            addr_q;
  logic [MRS_BYTE_W-1:0] rbyte;
  logic [MRS_PT_W-1:0]   u_press;
  logic [MRS_PT_W-1:0]   u_temp;
  logic [MRS_HUM_W-1:0]  u_hum;

  mrs_sync #(.RST_VAL(1'b1)) u_sync_rst (
    .clk  (link_clk),
    .rst  (1'b0),
    .din  (sys_rst),
    .dout (link_rst)
  );

  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      i2c_busy_q <= 1'b0;
    end else if (i2c_stop) begin
      i2c_busy_q <= 1'b0;
    end else if (i2c_start) begin
      i2c_busy_q <= 1'b1;
    end
  end

  // user word is static while a burst is open, so it is read directly
  // the link clock stops between bursts, so a link-side copy would go stale;
  // core writes user_q only while no burst is seen, so it is quasi-static
  assign u_press = user_q[MRS_PRESS_LSB +: MRS_PT_W];
  assign u_temp  = user_q[MRS_TEMP_LSB +: MRS_PT_W];
  assign u_hum   = user_q[MRS_HUM_LSB +: MRS_HUM_W];

  always_comb begin
    unique case (addr_q)
      MRS_A_PRESS_MSB:  rbyte = u_press[19:12];
      MRS_A_PRESS_LSB:  rbyte = u_press[11:4];
      MRS_A_PRESS_XLSB: rbyte = {u_press[3:0], 4'h0};
      MRS_A_TEMP_MSB:   rbyte = u_temp[19:12];
      MRS_A_TEMP_LSB:   rbyte = u_temp[11:4];
      MRS_A_TEMP_XLSB:  rbyte = {u_temp[3:0], 4'h0};
      MRS_A_HUM_MSB:    rbyte = u_hum[15:8];
      MRS_A_HUM_LSB:    rbyte = u_hum[7:0];
      default:          rbyte = MRS_BYTE_RST;
    endcase
  end

  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      addr_q <= MRS_ADDR_RST;
    end else if (addr_load) begin
      addr_q <= addr_in;
    end else if (byte_req) begin
      addr_q <= addr_q + 8'h01;
    end
  end

  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      rdata       <= MRS_BYTE_RST;
      rdata_valid <= 1'b0;
    end else begin
      rdata_valid <= byte_req & ~addr_load;
      if (byte_req && !addr_load) begin
        rdata <= rbyte;
      end
    end
  end

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  AST_MARKER: assert property (
    temp_skipped |-> in_word[MRS_TEMP_LSB +: MRS_PT_W] == MRS_SKIP_MARKER)
    else $error("skipped temperature not marked");

  AST_HOLD_IN_BURST: assert property (
    busy_s |=> $stable(user_q))
    else $error("user results changed during a burst");

  AST_SHADOW_LOAD: assert property (
    (pop && busy_s) |=> (shadow_q == $past(f_data)) && pend_q)
    else $error("shadow did not take latest result");

  AST_COMMIT: assert property (
    (burst_end && pend_q) |=> user_q == $past(shadow_q))
    else $error("shadow not committed at burst end");

  AST_ONE_STEP: assert property (
    burst_end |=> !pend_q ##1 $stable(user_q) || !busy_s)
    else $error("commit not completed in one step");

  AST_CS_END: assert property (
    ($rose(cs_n_s) && !i2c_busy_s) |-> burst_end && !f_ready)
    else $error("chip select rise not seen as burst end");

  AST_RAW_PASS: assert property (
    (pop && !busy_s && !burst_end) |=> user_q == $past(f_data))
    else $error("idle result not passed through raw");

  AST_PRESS_MARKER: assert property (
    press_skipped |-> in_word[MRS_PRESS_LSB +: MRS_PT_W] == MRS_SKIP_MARKER)
    else $error("skipped pressure not marked");

  AST_RAW_TEMP: assert property (
    !temp_skipped |-> in_word[MRS_TEMP_LSB +: MRS_PT_W] == raw_temperature)
    else $error("temperature not passed through raw");

  AST_RAW_PRESS: assert property (
    !press_skipped |-> in_word[MRS_PRESS_LSB +: MRS_PT_W] == raw_pressure)
    else $error("pressure not passed through raw");

  AST_RAW_HUM: assert property (
    in_word[MRS_HUM_LSB +: MRS_HUM_W] == raw_humidity)
    else $error("humidity field not 16 raw bits");

  AST_NO_POP_AT_END: assert property (
    burst_end |-> !pop)
    else $error("result drained in the commit cycle");

  AST_SHADOW_IDLE: assert property (
    !busy_s |=> $stable(shadow_q))
    else $error("shadow changed outside a burst");

  AST_PEND_IN_BURST: assert property (
    (!busy_s && !burst_end) |-> !pend_q)
    else $error("pending shadow left after burst end");

  AST_I2C_END: assert property (
    ($fell(i2c_busy_s) && cs_n_s) |-> burst_end && !f_ready)
    else $error("stop not seen as burst end");

  AST_ADDR_INC: assert property (
    @(posedge link_clk) disable iff (link_rst)
    (byte_req && !addr_load) |=> addr_q == $past(addr_q) + 8'h01)
    else $error("read address did not step by one");

  AST_XLSB_LOW: assert property (
    @(posedge link_clk) disable iff (link_rst)
    (byte_req && !addr_load && addr_q == MRS_A_TEMP_XLSB)
      |=> rdata_valid && rdata[3:0] == 4'h0)
    else $error("temperature xlsb low nibble not zero");

  AST_HUM_LSB: assert property (
    @(posedge link_clk) disable iff (link_rst)
    (byte_req && !addr_load && addr_q == MRS_A_HUM_LSB && i2c_busy_q)
      |=> rdata == $past(u_hum[7:0]))
    else $error("humidity low byte wrong at its address");

  AST_PRESS_MSB: assert property (
    @(posedge link_clk) disable iff (link_rst)
    (byte_req && !addr_load && addr_q == MRS_A_PRESS_MSB)
      |=> rdata == $past(u_press[19:12]))
    else $error("pressure high byte wrong at its address");

  AST_PRESS_XLSB: assert property (
    @(posedge link_clk) disable iff (link_rst)
    (byte_req && !addr_load && addr_q == MRS_A_PRESS_XLSB)
      |=> rdata == {$past(u_press[3:0]), 4'h0})
    else $error("pressure xlsb byte wrong");

  AST_HUM_MSB: assert property (
    @(posedge link_clk) disable iff (link_rst)
    (byte_req && !addr_load && addr_q == MRS_A_HUM_MSB)
      |=> rdata == $past(u_hum[15:8]))
    else $error("humidity high byte wrong at its address");

  AST_GAP_ZERO: assert property (
    @(posedge link_clk) disable iff (link_rst)
    (byte_req && !addr_load
      && !(addr_q inside {[MRS_A_PRESS_MSB:MRS_A_HUM_LSB]}))
      |=> rdata == MRS_BYTE_RST)
    else $error("byte outside the result window not zero");

  AST_ONE_BYTE: assert property (
    @(posedge link_clk) disable iff (link_rst)
    rdata_valid |-> $past(byte_req && !addr_load))
    else $error("byte returned without a request");

  AST_LOAD_WINS: assert property (
    @(posedge link_clk) disable iff (link_rst)
    addr_load |=> addr_q == $past(addr_in) && !rdata_valid)
    else $error("address load did not take priority");

  AST_STOP_WINS: assert property (
    @(posedge link_clk) disable iff (link_rst)
    i2c_stop |=> !i2c_busy_q)
    else $error("i2c stop did not close the burst");

  AST_START_OPENS: assert property (
    @(posedge link_clk) disable iff (link_rst)
    (i2c_start && !i2c_stop) |=> i2c_busy_q)
    else $error("i2c start did not open a burst");

  COV_COMMIT: cover property (burst_end && pend_q);
  COV_DIRECT: cover property (pop && !busy_s);
  COV_TWO_IN_BURST: cover property (
    (pop && busy_s) ##[1:200] (pop && busy_s));
  COV_FULL: cover property (!meas_ready);
  COV_I2C_END: cover property ($fell(i2c_busy_s));

endmodule : mrs_top

// ---- mrs_host.sv ----
// mrs_host: behavioural serial host driving the link side of mrs_top.
// assumes: the bench calls its tasks; link clock runs only inside bursts and during idle calls.
`timescale 1ns/1ps
module mrs_host (
  // link clock and framing
  output logic            link_clk,
  output logic            chip_select_n,
  output logic            i2c_start,
  output logic            i2c_stop,
  // read requests
  output logic            addr_load,
  output logic [7:0]      addr_in,
  output logic            byte_req,
  // returned bytes
  input  wire logic [7:0] rdata,
  input  wire logic       rdata_valid
);
  logic [7:0] got [0:15];
  int         ngot;
  bit         spi;

  initial begin
    link_clk = 1'b0;
    chip_select_n = 1'b1;
    {i2c_start, i2c_stop, addr_load, byte_req} = 4'h0;
    addr_in = 8'h00;
  end

  // one link period; bytes are taken just before the rising edge
  task automatic tick();
    #62.5;
    if (rdata_valid === 1'b1 && ngot < 16) begin
      got[ngot] = rdata;
      ngot++;
    end
    link_clk = 1'b1;
    #62.5;
    link_clk = 1'b0;
  endtask : tick

  task automatic idle(input int n);
    repeat (n) tick();
  endtask : idle

  task automatic open(input bit use_spi);
    spi = use_spi;
    ngot = 0;
    if (spi) chip_select_n = 1'b0;
    else i2c_start = 1'b1;
    tick();
    i2c_start = 1'b0;
    tick();
  endtask : open

  task automatic load(input logic [7:0] a);
    addr_load = 1'b1;
    addr_in = a;
    tick();
    addr_load = 1'b0;
    addr_in = ~a;
  endtask : load

  // byte request together with a load: only the address may move
  task automatic load_req(input logic [7:0] a);
    {addr_load, byte_req} = 2'b11;
    addr_in = a;
    tick();
    {addr_load, byte_req} = 2'b00;
    addr_in = ~a;
  endtask : load_req

  task automatic read(input int n);
    repeat (n) begin
      byte_req = 1'b1;
      tick();
    end
    byte_req = 1'b0;
    tick();
    tick();
  endtask : read

  // clock stands still after select rises; stop needs link edges
  task automatic close();
    if (spi) chip_select_n = 1'b1;
    else begin
      i2c_stop = 1'b1;
      tick();
      i2c_stop = 1'b0;
      tick();
      tick();
    end
  endtask : close
endmodule : mrs_host

// ---- tb_top.sv ----
// tb_top: directed bench for the result window and its shadow copy.
// assumes: mrs_host drives the link side; results arrive on core_clk.
`timescale 1ns/1ps
module tb_top;
  logic        core_clk, sys_rst, meas_valid, meas_ready;
  logic        temp_skipped, press_skipped;
  logic [19:0] raw_temperature, raw_pressure;
  logic [15:0] raw_humidity;
  logic        link_clk, chip_select_n, i2c_start, i2c_stop;
  logic        addr_load, byte_req, rdata_valid;
  logic [7:0]  addr_in, rdata;
  int          miscompares, compares;
  localparam logic [19:0] MARK = 20'h8_0000;

  mrs_top DUT (.core_clk, .sys_rst, .meas_valid, .meas_ready,
    .raw_temperature, .raw_pressure, .raw_humidity, .temp_skipped,
    .press_skipped, .link_clk, .chip_select_n, .i2c_start, .i2c_stop,
    .addr_load, .addr_in, .byte_req, .rdata, .rdata_valid);
  mrs_host host (.link_clk, .chip_select_n, .i2c_start, .i2c_stop,
    .addr_load, .addr_in, .byte_req, .rdata, .rdata_valid);

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic end_sim();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_sim

  task automatic check(input string nm, input logic [19:0] e, g);
    compares++;
    if (g !== e) begin
      $display("unexpected %s: expected %h seen %h", nm, e, g);
      miscompares++;
    end
  endtask : check

  function automatic logic [7:0] expb(input logic [19:0] p, t,
                                     input logic [15:0] h,
                                     input logic [7:0] a);
    case (a)
      8'hF7: return p[19:12];
      8'hF8: return p[11:4];
      8'hF9: return {p[3:0], 4'h0};
      8'hFA: return t[19:12];
      8'hFB: return t[11:4];
      8'hFC: return {t[3:0], 4'h0};
      8'hFD: return h[15:8];
      8'hFE: return h[7:0];
      default: return 8'h00;
    endcase
  endfunction : expb

  task automatic chk_burst(input logic [19:0] p, t, input logic [15:0] h,
                           input logic [7:0] a0, input int n);
    check("byte count", 20'(n), 20'(host.ngot));
    for (int i = 0; i < n; i++)
      check($sformatf("byte %h", 8'(a0 + i)), 20'(expb(p, t, h, 8'(a0 + i))),
            20'(host.got[i]));
  endtask : chk_burst

  task automatic push(input logic [19:0] p, t, input logic [15:0] h,
                      input bit ts, ps);
    @(negedge core_clk);
    meas_valid = 1'b1;
    {raw_pressure, raw_temperature, raw_humidity} = {p, t, h};
    {temp_skipped, press_skipped} = {ts, ps};
    while (meas_ready !== 1'b1) @(negedge core_clk);
    @(negedge core_clk);
    meas_valid = 1'b0;
    {raw_pressure, raw_temperature, raw_humidity} = ~{p, t, h};
  endtask : push

  task automatic settle();
    repeat (10) @(negedge core_clk);
  endtask : settle

  task automatic burst(input bit spi, input logic [7:0] a, input int n);
    host.open(spi);
    host.load(a);
    host.read(n);
    host.close();
    settle();
  endtask : burst

  task automatic t_plain();
    push(20'h1_2345, 20'h6_789A, 16'hBCDE, 1'b0, 1'b0);
    settle();
    burst(1'b1, 8'hF7, 8);
    chk_burst(20'h1_2345, 20'h6_789A, 16'hBCDE, 8'hF7, 8);
    burst(1'b0, 8'hFC, 4);
    chk_burst(20'h1_2345, 20'h6_789A, 16'hBCDE, 8'hFC, 4);
    host.open(1'b1);
    host.load_req(8'hFD);
    host.read(2);
    host.close();
    settle();
    chk_burst(20'h1_2345, 20'h6_789A, 16'hBCDE, 8'hFD, 2);
  endtask : t_plain

  task automatic t_skip();
    push(20'h0_F00F, 20'hF_0F0F, 16'h5A5A, 1'b1, 1'b1);
    settle();
    burst(1'b0, 8'hF7, 8);
    chk_burst(MARK, MARK, 16'h5A5A, 8'hF7, 8);
  endtask : t_skip

  // two results land mid-burst; old set must stay whole until burst end
  task automatic t_shadow(input bit spi, input logic [19:0] op, ot,
                          input logic [15:0] oh, input logic [19:0] np, nt,
                          input logic [15:0] nh);
    host.open(spi);
    host.load(8'hF7);
    host.read(2);
    push(20'h0_0001, 20'h0_0002, 16'h0003, 1'b0, 1'b0);
    push(np, nt, nh, 1'b0, 1'b0);
    settle();
    host.read(2);
    chk_burst(op, ot, oh, 8'hF7, 4);
    host.close();
    settle();
    burst(spi, 8'hF7, 8);
    chk_burst(np, nt, nh, 8'hF7, 8);
  endtask : t_shadow

  initial begin
    {sys_rst, meas_valid, temp_skipped, press_skipped} = 4'h8;
    {raw_pressure, raw_temperature, raw_humidity} = '0;
    host.idle(4);
    repeat (8) @(negedge core_clk);
    sys_rst = 1'b0;
    host.idle(3);
    check("meas_ready", 20'h0_0001, 20'(meas_ready));
    check("rdata", 20'h0_0000, 20'(rdata));
    t_plain();
    t_skip();
    t_shadow(1'b1, MARK, MARK, 16'h5A5A, 20'hC_3C3C, 20'h3_C3C3, 16'hA5A5);
    t_shadow(1'b0, 20'hC_3C3C, 20'h3_C3C3, 16'hA5A5,
             20'h9_8765, 20'h4_3210, 16'h0FF0);
    end_sim();
  end

  // watchdog well beyond the longest expected run
  initial begin
    #100_000;
    miscompares++;
    end_sim();
  end
endmodule : tb_top
